/* mcu_side_model.sv */
// Microcontroller side model: reset pin, address strobe and input clock
`timescale 1ns/10ps
module mcu_side_model (
	// Clock and control
	input wire clk_sys_i,
	input wire rst_go_i,
	input wire [15:0] rst_len_i,
	input wire pulse_i,
	input wire lclk_run_i,
	input wire idle_pol_i,
	// Pins
	output reg reset_n_o,
	output reg strobe_o,
	output reg lclk_o
);
reg [15:0] cnt_reg = 16'h0000;
initial reset_n_o = 1'b0;
initial strobe_o = 1'b1;
initial lclk_o = 1'b1;
always @(posedge clk_sys_i) begin
	if (rst_go_i) begin
		cnt_reg <= rst_len_i;
		reset_n_o <= 1'b0;
	end else if (cnt_reg != 16'h0000) begin
		cnt_reg <= cnt_reg - 16'h0001;
		reset_n_o <= (cnt_reg == 16'h0001);
	end
	strobe_o <= pulse_i ? ~strobe_o : idle_pol_i;
	lclk_o <= lclk_run_i ? ~lclk_o : 1'b1;
end
endmodule // mcu_side_model

/* pd_counter.v */
// Power-down idle counter on the logic input clock
`timescale 1ns/10ps
module pd_counter (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_n_i,
	// Control
	input wire enable_i,
	input wire strobe_edge_i,
	input wire strobe_idle_i,
	input wire clk_tick_i,
	// Status
	output reg power_down_o
);
`include "pwr_rst_consts.vh"
reg [3:0] cnt_reg;
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		cnt_reg <= 4'h0;
		power_down_o <= 1'b0;
	end else if (!enable_i || strobe_edge_i) begin
		cnt_reg <= 4'h0;
		if (strobe_edge_i)
			power_down_o <= 1'b0;
	end else if (strobe_idle_i && clk_tick_i) begin
		if (cnt_reg != `PD_COUNT)
			cnt_reg <= cnt_reg + 4'h1;
		if (cnt_reg == `PD_COUNT - 4'h1)
			power_down_o <= 1'b1;
	end
end
endmodule // pd_counter

/* power_saving_and_reset_control.v */
// Power saving gating and reset sequencing for the memory-and-logic peripheral
`timescale 1ns/10ps
module power_saving_and_reset_control (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_n_i,
	// Device pins
	input wire reset_n_pin_i,
	input wire chip_select_n_i,
	input wire address_strobe_i,
	input wire logic_input_clock_i,
	input wire [7:0] addr_low_i,
	input wire [2:0] control_lines_i,
	input wire write_high_byte_i,
	// Configuration
	input wire [7:0] power_ctrl_a_wdata_i,
	input wire power_ctrl_a_we_i,
	input wire [7:0] power_ctrl_c_wdata_i,
	input wire power_ctrl_c_we_i,
	input wire auto_power_down_i,
	input wire strobe_idle_pol_i,
	input wire [7:0] map_default_i,
	input wire [7:0] map_wdata_i,
	input wire map_we_i,
	input wire logic_activity_i,
	// Flash status
	input wire flash_busy_i,
	// Power registers and memory map
	output reg [7:0] power_ctrl_reg_a_o,
	output reg [7:0] power_ctrl_reg_c_o,
	output reg [7:0] memory_map_reg_o,
	// Gated logic inputs
	output reg [7:0] logic_addr_o,
	output reg [2:0] logic_ctrl_o,
	output reg logic_strobe_o,
	output reg logic_wrh_o,
	output reg logic_clk_and_o,
	output reg logic_clk_mc_o,
	// Power states
	output reg logic_turbo_o,
	output reg logic_standby_o,
	output reg power_down_flag_o,
	output reg mem_select_o,
	output reg io_select_o,
	// Reset outputs
	output reg in_reset_o,
	output reg por_active_o,
	output reg config_load_o,
	output reg macrocell_clear_o,
	output reg logic_out_valid_o,
	output reg flash_reset_o,
	output reg flash_read_mode_o,
	output reg io_input_mode_o,
	output reg addr_out_float_o,
	output reg data_float_o,
	output reg periph_float_o
);
`include "pwr_rst_consts.vh"
localparam [3:0] ST_POR = 4'b0001;
localparam [3:0] ST_POST = 4'b0010;
localparam [3:0] ST_RUN = 4'b0100;
localparam [3:0] ST_WARM = 4'b1000;
parameter PO_CYC = `PO_RESET_CYC;
parameter ABORT_CYC = `ABORT_RESET_CYC;

function rising;
	input cur;
	input prev;
	begin
		rising = cur & ~prev;
	end
endfunction

// Pin synchronisers
reg [1:0] rst_s1_reg, sel_s1_reg;
reg [1:0] ale_s1_reg, clk_s1_reg;
reg [7:0] addr_s1_reg, addr_s2_reg;
reg [3:0] ctl_s1_reg, ctl_s2_reg;
reg ale_d_reg, clk_d_reg;
reg [3:0] state_reg;
reg [15:0] low_cnt_reg;
reg [2:0] post_cnt_reg;
reg por_done_reg;
reg [1:0] idle_cnt_reg;
reg [7:0] addr_prev_reg;
reg busy_abort_reg;
wire rst_pin, sel_n, ale, lclk, strobe_edge, clk_tick, pd_now;
wire [7:0] addr_g;
wire [3:0] ctl_g;

always @(posedge clk_sys_i) begin
	rst_s1_reg <= {rst_s1_reg[0], reset_n_pin_i};
	sel_s1_reg <= {sel_s1_reg[0], chip_select_n_i};
	ale_s1_reg <= {ale_s1_reg[0], address_strobe_i};
	clk_s1_reg <= {clk_s1_reg[0], logic_input_clock_i};
	addr_s1_reg <= addr_low_i;
	addr_s2_reg <= addr_s1_reg;
	ctl_s1_reg <= {write_high_byte_i, control_lines_i};
	ctl_s2_reg <= ctl_s1_reg;
	ale_d_reg <= ale_s1_reg[1];
	clk_d_reg <= clk_s1_reg[1];
end
assign rst_pin = rst_s1_reg[1];
assign sel_n = sel_s1_reg[1];
assign ale = ale_s1_reg[1];
assign lclk = clk_s1_reg[1];
assign addr_g = addr_s2_reg;
assign ctl_g = ctl_s2_reg;
assign strobe_edge = ale ^ ale_d_reg;
assign clk_tick = rising(lclk, clk_d_reg);

pd_counter u_pd (
	.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i && rst_pin),
	.enable_i(auto_power_down_i),
	.strobe_edge_i(strobe_edge || !sel_n),
	.strobe_idle_i(ale == strobe_idle_pol_i),
	.clk_tick_i(clk_tick),
	.power_down_o(pd_now)
);

// Reset sequencer
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		state_reg <= ST_POR;
		low_cnt_reg <= 16'h0000;
		post_cnt_reg <= 3'h0;
		por_done_reg <= 1'b0;
		busy_abort_reg <= 1'b0;
	end else begin
		case (state_reg)
		ST_POR: begin
			if (!rst_pin) begin
				if (low_cnt_reg != 16'hFFFF)
					low_cnt_reg <= low_cnt_reg + 16'h0001;
			end else if (low_cnt_reg >= PO_CYC[15:0]) begin
				por_done_reg <= 1'b1;
				post_cnt_reg <= 3'h0;
				state_reg <= ST_POST;
			end else begin
				low_cnt_reg <= 16'h0000;
			end
		end
		ST_POST: begin
			if (!rst_pin) begin
				low_cnt_reg <= 16'h0000;
				state_reg <= ST_WARM;
			end else if (post_cnt_reg == `POST_RESET_CYC - 1)
				state_reg <= ST_RUN;
			else
				post_cnt_reg <= post_cnt_reg + 3'h1;
		end
		ST_RUN: begin
			if (!rst_pin) begin
				low_cnt_reg <= 16'h0000;
				busy_abort_reg <= flash_busy_i;
				state_reg <= ST_WARM;
			end
		end
		ST_WARM: begin
			if (!rst_pin) begin
				if (low_cnt_reg != 16'hFFFF)
					low_cnt_reg <= low_cnt_reg + 16'h0001;
				if (busy_abort_reg && low_cnt_reg >= ABORT_CYC[15:0])
					busy_abort_reg <= 1'b0;
			end else if (low_cnt_reg >= `WARM_RESET_CYC) begin
				post_cnt_reg <= 3'h0;
				state_reg <= ST_POST;
			end else begin
				state_reg <= ST_RUN;
			end
		end
		default: state_reg <= ST_POR;
		endcase
	end
end

// Power registers and memory map
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		power_ctrl_reg_a_o <= `PCTRL_RESET;
		power_ctrl_reg_c_o <= `PCTRL_RESET;
		memory_map_reg_o <= `MAP_DEFAULT;
	end else if (state_reg == ST_POR) begin
		power_ctrl_reg_a_o <= `PCTRL_RESET;
		power_ctrl_reg_c_o <= `PCTRL_RESET;
		memory_map_reg_o <= map_default_i & ~8'h0081;
	end else if (state_reg == ST_WARM) begin
		memory_map_reg_o <= map_default_i & ~8'h0081;
	end else if (state_reg == ST_RUN && !power_down_flag_o) begin
		if (power_ctrl_a_we_i)
			power_ctrl_reg_a_o <= power_ctrl_a_wdata_i;
		if (power_ctrl_c_we_i)
			power_ctrl_reg_c_o <= power_ctrl_c_wdata_i;
		if (map_we_i)
			memory_map_reg_o <= map_wdata_i;
	end
end

// Logic idle detection for turbo-off standby
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		idle_cnt_reg <= 2'h0;
		addr_prev_reg <= 8'h00;
	end else begin
		addr_prev_reg <= logic_addr_o;
		if (logic_activity_i || addr_prev_reg != logic_addr_o)
			idle_cnt_reg <= 2'h0;
		else if (idle_cnt_reg != `IDLE_CYC)
			idle_cnt_reg <= idle_cnt_reg + 2'h1;
	end
end

// Gating and status outputs
always @(posedge clk_sys_i) begin
	if (!rst_n_i) begin
		logic_addr_o <= 8'h00;
		logic_ctrl_o <= 3'h0;
		logic_strobe_o <= 1'b0;
		logic_wrh_o <= 1'b0;
		logic_clk_and_o <= 1'b0;
		logic_clk_mc_o <= 1'b0;
		logic_turbo_o <= 1'b1;
		logic_standby_o <= 1'b0;
		power_down_flag_o <= 1'b0;
		mem_select_o <= 1'b0;
		io_select_o <= 1'b0;
		in_reset_o <= 1'b1;
		por_active_o <= 1'b1;
		config_load_o <= 1'b1;
		macrocell_clear_o <= 1'b1;
		logic_out_valid_o <= 1'b0;
		flash_reset_o <= 1'b1;
		flash_read_mode_o <= 1'b1;
		io_input_mode_o <= 1'b1;
		addr_out_float_o <= 1'b1;
		data_float_o <= 1'b1;
		periph_float_o <= 1'b1;
	end else begin
		power_down_flag_o <= pd_now && sel_n && state_reg == ST_RUN;
		logic_addr_o <= (power_ctrl_reg_c_o[`BLK_ADDR_BIT] || pd_now) ? 8'h00 : addr_g;
		logic_ctrl_o[0] <= (power_ctrl_reg_c_o[`BLK_CTL0_BIT] || pd_now) ? 1'b0 : ctl_g[0];
		logic_ctrl_o[1] <= (power_ctrl_reg_c_o[`BLK_CTL1_BIT] || pd_now) ? 1'b0 : ctl_g[1];
		logic_ctrl_o[2] <= (power_ctrl_reg_c_o[`BLK_CTL2_BIT] || pd_now) ? 1'b0 : ctl_g[2];
		logic_strobe_o <= (power_ctrl_reg_c_o[`BLK_STROBE_BIT] || pd_now) ? 1'b0 : ale;
		logic_wrh_o <= (power_ctrl_reg_c_o[`BLK_WRH_BIT] || pd_now) ? 1'b0 : ctl_g[3];
		logic_clk_and_o <= power_ctrl_reg_a_o[`CLK_AND_BIT] ? 1'b0 : lclk;
		logic_clk_mc_o <= power_ctrl_reg_a_o[`CLK_MC_BIT] ? 1'b0 : lclk;
		logic_turbo_o <= ~power_ctrl_reg_a_o[`TURBO_BIT];
		logic_standby_o <= power_ctrl_reg_a_o[`TURBO_BIT] && idle_cnt_reg == `IDLE_CYC;
		mem_select_o <= !sel_n && !pd_now && state_reg == ST_RUN;
		io_select_o <= !sel_n && state_reg == ST_RUN;
		in_reset_o <= state_reg != ST_RUN;
		por_active_o <= state_reg == ST_POR;
		config_load_o <= state_reg == ST_POR;
		macrocell_clear_o <= state_reg == ST_POR;
		logic_out_valid_o <= por_done_reg || state_reg != ST_POR;
		flash_reset_o <= state_reg == ST_POR || state_reg == ST_WARM;
		flash_read_mode_o <= !(busy_abort_reg || (flash_busy_i && state_reg == ST_RUN));
		io_input_mode_o <= state_reg != ST_RUN;
		addr_out_float_o <= state_reg != ST_RUN;
		data_float_o <= state_reg != ST_RUN || pd_now;
		periph_float_o <= state_reg != ST_RUN || pd_now;
	end
end
endmodule // power_saving_and_reset_control

/* power_saving_and_reset_control_props.sv */
// Assertion checker for the power saving and reset controller
`timescale 1ns/10ps
module pwr_rst_props (
	// Clock, reset, inputs
	input wire clk_sys_i, rst_n_i, auto_power_down_i,
	// Outputs watched
	input wire [7:0] power_ctrl_reg_a_o, power_ctrl_reg_c_o, logic_addr_o,
	input wire logic_strobe_o, logic_clk_and_o, logic_clk_mc_o, logic_turbo_o,
	input wire logic_standby_o, power_down_flag_o, mem_select_o, in_reset_o, por_active_o,
	input wire logic_out_valid_o, io_input_mode_o, data_float_o, periph_float_o, addr_out_float_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!rst_n_i);
reg [7:0] a1, a2, c1, c2;
reg [2:0] up;
reg w1;
wire [7:0] a = power_ctrl_reg_a_o;
wire [7:0] c = power_ctrl_reg_c_o;
wire sa = (a == a1) && (a1 == a2);
wire sc = (c == c1) && (c1 == c2);
wire warm = in_reset_o && !por_active_o;
always @(posedge clk_sys_i) begin
	a1 <= a;
	a2 <= a1;
	c1 <= c;
	c2 <= c1;
	w1 <= warm;
	up <= !rst_n_i ? 3'd0 : (up == 3'd7 ? 3'd7 : up + 3'd1);
end
property p_turbo; sa |-> logic_turbo_o == !a[3]; endproperty
a_turbo: assert property (p_turbo) else $error("turbo mismatch");
property p_standby; sa && !a[3] |-> !logic_standby_o; endproperty
a_standby: assert property (p_standby) else $error("standby in turbo");
property p_clk_and; sa && a[4] |-> !logic_clk_and_o; endproperty
a_clk_and: assert property (p_clk_and) else $error("array clock not gated");
property p_clk_mc; sa && a[5] |-> !logic_clk_mc_o; endproperty
a_clk_mc: assert property (p_clk_mc) else $error("macrocell clock not gated");
property p_blk_addr; sc && c[0] |-> logic_addr_o == 8'h00; endproperty
a_blk_addr: assert property (p_blk_addr) else $error("address not blocked");
property p_blk_strb; sc && c[5] |-> !logic_strobe_o; endproperty
a_blk_strb: assert property (p_blk_strb) else $error("strobe not blocked");
property p_pd_mem; power_down_flag_o && $past(power_down_flag_o) |-> !mem_select_o; endproperty
a_pd_mem: assert property (p_pd_mem) else $error("memory selected in power-down");
property p_pd_hold; (!auto_power_down_i) [*4] |-> !$rose(power_down_flag_o); endproperty
a_pd_hold: assert property (p_pd_hold) else $error("power-down while disabled");
property p_warm_keep; up == 3'd7 && warm && w1 |-> $stable(a) && logic_out_valid_o; endproperty
a_warm_keep: assert property (p_warm_keep) else $error("warm reset lost state");
property p_rst_pins;
	up == 3'd7 && in_reset_o && $past(in_reset_o) |->
		io_input_mode_o && data_float_o && periph_float_o && addr_out_float_o;
endproperty
a_rst_pins: assert property (p_rst_pins) else $error("pin state in reset");
c_pd: cover property ($rose(power_down_flag_o));
c_warm: cover property (up == 3'd7 && warm && w1);
c_standby: cover property (logic_standby_o);
endmodule // pwr_rst_props
bind power_saving_and_reset_control pwr_rst_props u_props (.*);

/* power_saving_and_reset_control_tb.sv */
// Self-checking bench for the power saving and reset controller
`timescale 1ns/10ps
module power_saving_and_reset_control_tb;
reg clk_sys_i = 1'b0;
reg rst_n_i = 1'b0;
reg cs_n = 1'b0, auto = 1'b0, fbusy = 1'b0, we = 1'b0, we_m = 1'b0;
reg pulse = 1'b0, lrun = 1'b0, rst_go = 1'b1;
reg [7:0] wa = 8'h00, wc = 8'h00, ad = 8'h00, mw = 8'h00;
reg ipol = 1'b1, act = 1'b0;
reg [2:0] ctl = 3'h5;
reg [15:0] rlen = 16'h0016;
reg [15:0] rows [0:3];
wire pin_n, strb, lclk, lstrb, lwrh, lcand, lcmc, turbo, stby, pdf, msel, inrst, flrd, ioin, dfl;
wire [7:0] ra, rc, rm, laddr;
wire [2:0] lctl;
integer miscompares = 0, check_count = 0, i, n;
always #25 clk_sys_i = ~clk_sys_i;
mcu_side_model u_mcu (.clk_sys_i(clk_sys_i), .rst_go_i(rst_go), .rst_len_i(rlen),
	.pulse_i(pulse), .lclk_run_i(lrun), .idle_pol_i(ipol), .reset_n_o(pin_n),
	.strobe_o(strb), .lclk_o(lclk));
power_saving_and_reset_control #(.PO_CYC(20), .ABORT_CYC(5)) u_dut (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .reset_n_pin_i(pin_n), .chip_select_n_i(cs_n), .address_strobe_i(strb),
	.logic_input_clock_i(lclk), .addr_low_i(ad), .control_lines_i(ctl),
	.write_high_byte_i(1'b1), .power_ctrl_a_wdata_i(wa), .power_ctrl_a_we_i(we),
	.power_ctrl_c_wdata_i(wc), .power_ctrl_c_we_i(we), .auto_power_down_i(auto),
	.strobe_idle_pol_i(ipol), .map_default_i(8'hFF), .map_wdata_i(mw), .map_we_i(we_m),
	.logic_activity_i(act), .flash_busy_i(fbusy), .power_ctrl_reg_a_o(ra),
	.power_ctrl_reg_c_o(rc), .memory_map_reg_o(rm), .logic_addr_o(laddr), .logic_ctrl_o(lctl),
	.logic_strobe_o(lstrb), .logic_wrh_o(lwrh), .logic_clk_and_o(lcand), .logic_clk_mc_o(lcmc),
	.logic_turbo_o(turbo), .logic_standby_o(stby), .power_down_flag_o(pdf),
	.mem_select_o(msel), .io_select_o(), .in_reset_o(inrst), .por_active_o(),
	.config_load_o(), .macrocell_clear_o(), .logic_out_valid_o(), .flash_reset_o(),
	.flash_read_mode_o(flrd), .io_input_mode_o(ioin), .addr_out_float_o(),
	.data_float_o(dfl), .periph_float_o());
task chk(input [7:0] got, input [7:0] exp); begin
	check_count = check_count + 1;
	if (got !== exp) begin
		miscompares = miscompares + 1;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
end endtask
task tick(input integer k); begin
	repeat (k) @(posedge clk_sys_i);
	@(negedge clk_sys_i);
end endtask
task wr(input [7:0] a, input [7:0] c); begin
	@(posedge clk_sys_i);
	wa <= a;
	wc <= c;
	ad <= c ^ 8'hA5;
	we <= 1'b1;
	@(posedge clk_sys_i);
	we <= 1'b0;
	tick(6);
end endtask
task rst_pin(input [15:0] len); begin
	@(posedge clk_sys_i);
	rlen <= len;
	rst_go <= 1'b1;
	@(posedge clk_sys_i);
	rst_go <= 1'b0;
end endtask
task wait_run; begin
	n = 0;
	while (inrst !== 1'b0 && n < 200) begin
		tick(1);
		n = n + 1;
	end
	chk(inrst, 8'h00);
	tick(2);
end endtask
task test_done; begin
	$display("Checks %0d, miscompares %0d", check_count, miscompares);
	if (miscompares == 0 && check_count > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
end endtask
initial begin
	#(50 * 4000);
	miscompares = miscompares + 1;
	test_done;
end
initial begin
	rows[0] = 16'h0000;
	rows[1] = 16'h0801;
	rows[2] = 16'h107C;
	rows[3] = 16'h387D;
	tick(12);
	@(posedge clk_sys_i);
	rst_n_i <= 1'b1;
	rst_go <= 1'b0;
	wait_run;
	chk(ra, 8'h00);
	chk(rm, 8'h7E);
	chk(flrd, 8'h01);
	$display("Power-on test done");
	for (i = 0; i < 4; i = i + 1) begin
		wr(rows[i][15:8], rows[i][7:0]);
		chk(ra, wa);
		chk(rc, wc);
		chk(turbo, !wa[3]);
		chk(stby, wa[3]);
		chk(lcand, !wa[4]);
		chk(lcmc, !wa[5]);
		chk(laddr, wc[0] ? 8'h00 : ad);
		chk(lctl, 3'h5 & ~wc[4:2]);
		chk(lstrb, !wc[5]);
		chk(lwrh, !wc[6]);
		chk(msel, 8'h01);
	end
	$display("Table test done");
	@(posedge clk_sys_i);
	act <= 1'b1;
	tick(4);
	chk(stby, 8'h00);
	@(posedge clk_sys_i);
	act <= 1'b0;
	we_m <= 1'b1;
	mw <= 8'h5A;
	@(posedge clk_sys_i);
	we_m <= 1'b0;
	tick(1);
	chk(rm, 8'h5A);
	rst_pin(1);
	tick(8);
	chk(inrst, 8'h00);
	@(posedge clk_sys_i);
	fbusy <= 1'b1;
	rst_pin(8);
	tick(5);
	chk(inrst, 8'h01);
	chk(ioin, 8'h01);
	chk(dfl, 8'h01);
	@(posedge clk_sys_i);
	fbusy <= 1'b0;
	wait_run;
	chk(ra, 8'h38);
	chk(rm, 8'h7E);
	chk(flrd, 8'h01);
	$display("Warm reset test done");
	wr(8'h30, 8'h00);
	@(posedge clk_sys_i);
	cs_n <= 1'b1;
	lrun <= 1'b1;
	tick(60);
	chk(msel, 8'h00);
	chk(lctl, 3'h5);
	chk(pdf, 8'h00);
	for (i = 0; i < 2; i = i + 1) begin
		@(posedge clk_sys_i);
		auto <= 1'b1;
		n = 0;
		while (pdf !== 1'b1 && n < 100) begin
			tick(1);
			n = n + 1;
		end
		chk(n >= 28, 8'h01);
		chk(pdf, 8'h01);
		chk(laddr, 8'h00);
		wr(8'h08, 8'h00);
		chk(ra, 8'h30);
		@(posedge clk_sys_i);
		if (i == 0)
			pulse <= 1'b1;
		else
			cs_n <= 1'b0;
		tick(8);
		chk(pdf, 8'h00);
		chk(msel, i == 1);
		@(posedge clk_sys_i);
		pulse <= 1'b0;
		cs_n <= 1'b1;
		auto <= 1'b0;
	end
	$display("Power-down test done");
	test_done;
end
endmodule // power_saving_and_reset_control_tb

/* pwr_rst_consts.vh */
// Constants for the power saving and reset controller
`ifndef PWR_RST_CONSTS_VH
`define PWR_RST_CONSTS_VH
`define CLK_PERIOD_NS 50
`define TURBO_BIT 3
`define CLK_AND_BIT 4
`define CLK_MC_BIT 5
`define BLK_ADDR_BIT 0
`define BLK_CTL0_BIT 2
`define BLK_CTL1_BIT 3
`define BLK_CTL2_BIT 4
`define BLK_STROBE_BIT 5
`define BLK_WRH_BIT 6
`define PCTRL_RESET 8'h00
`define IDLE_NS 70
`define IDLE_CYC ((`IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PD_COUNT 4'h000F
`define POST_RESET_NS 120
`define POST_RESET_CYC ((`POST_RESET_NS / `CLK_PERIOD_NS) < 1 ? 1 : (`POST_RESET_NS / `CLK_PERIOD_NS))
`define PO_RESET_US 1000
`define PO_RESET_CYC (`PO_RESET_US * 1000 / `CLK_PERIOD_NS)
`define WARM_RESET_NS 150
`define WARM_RESET_CYC ((`WARM_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ABORT_RESET_US 25
`define ABORT_RESET_CYC (`ABORT_RESET_US * 1000 / `CLK_PERIOD_NS)
`define MAP_BOOT_BIT 0
`define MAP_PERIPH_BIT 7
`define MAP_DEFAULT 8'h0000
`endif
